// ### rtl/rorc_pkg.sv
// Constants and types for the reference offset command registers
package rorc_pkg;
  // Command codes of the two offset registers
  localparam logic [7:0] CMD_TRIM_C = 8'hD4;
  localparam logic [7:0] CMD_MARGIN_HIGH_C = 8'hD5;
  // Fixed output voltage exponent and code step in microvolts
  localparam int VOUT_EXP_C = -9;
  localparam int STEP_UV_C = 1953;
  // Trim offset: reset, limits, stored width
  localparam logic [15:0] TRIM_RST_C = 16'h0000;
  localparam logic signed [15:0] TRIM_MAX_C = 16'sh003F;
  localparam logic signed [15:0] TRIM_MIN_C = 16'shFFC0;
  localparam int TRIM_W_C = 7;
  // Margin-high offset: limits, restore values, stored width
  localparam logic signed [15:0] MH_MAX_C = 16'sh001F;
  localparam logic signed [15:0] MH_MIN_C = 16'sh0000;
  localparam logic [15:0] MH_RESTORE0_C = 16'h0009;
  localparam logic [15:0] MH_RESTORE1_C = 16'h000F;
  localparam int MH_W_C = 5;
  // Margin-low term limits
  localparam logic signed [15:0] ML_MAX_C = 16'shFFFF;
  localparam logic signed [15:0] ML_MIN_C = 16'shFFC0;
  // Loop scale is unsigned with this many fraction bits
  localparam int SCALE_SHIFT_C = 7;
  // Operation bits that select the margins
  localparam int OP_MARGIN_HIGH_BIT_C = 5;
  localparam int OP_MARGIN_LOW_BIT_C = 4;
  // Start-up counts from 0 to this value, one cycle each, before host access opens
  localparam logic [1:0] INIT_CYC_C = 2'h3;

  typedef enum logic [2:0] {
    CONV_OFF,
    CONV_SOFT_START,
    CONV_STEADY,
    CONV_TOFF_DELAY,
    CONV_SOFT_STOP
  } rorc_conv_e;

  typedef enum logic {
    PH_INIT,
    PH_READY
  } rorc_phase_e;
endpackage

// ### rtl/rorc_link_port.sv
// Link-clock side of the host command port with toggle handshake
`timescale 1ns/1ps
module rorc_link_port (
  input wire logic lclk,
  input wire logic rst,
  input wire logic pm_valid,
  input wire logic pm_write,
  input wire logic [7:0] pm_cmd,
  input wire logic [15:0] pm_wdata,
  output logic pm_busy,
  output logic pm_done,
  output logic pm_nack,
  output logic [15:0] pm_rdata,
  output logic req_tgl,
  output logic [7:0] req_cmd,
  output logic req_write,
  output logic [15:0] req_wdata,
  input wire logic ack_tgl,
  input wire logic ack_nack,
  input wire logic [15:0] ack_rdata
);
  import rorc_pkg::*;

  typedef struct packed {
    logic req_tgl;
    logic [7:0] cmd;
    logic wr;
    logic [15:0] wdata;
    logic ack_s1;
    logic ack_s2;
    logic ack_seen;
    logic busy;
    logic done;
    logic nack;
    logic [15:0] rdata;
  } rorc_link_s;

  rorc_link_s s_q;
  rorc_link_s s_d;

  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    s_d.ack_s1 = ack_tgl;
    s_d.ack_s2 = s_q.ack_s1;
    if (pm_valid && !s_q.busy) begin
      s_d.cmd = pm_cmd;
      s_d.wr = pm_write;
      s_d.wdata = pm_wdata;
      s_d.req_tgl = ~s_q.req_tgl;
      s_d.busy = 1'b1;
    end else if (s_q.busy && (s_q.ack_s2 != s_q.ack_seen)) begin
      // Core holds its answer stable from its toggle onward
      s_d.ack_seen = s_q.ack_s2;
      s_d.busy = 1'b0;
      s_d.done = 1'b1;
      s_d.nack = ack_nack;
      s_d.rdata = ack_rdata;
    end
  end

  always_ff @(posedge lclk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign pm_busy = s_q.busy;
  assign pm_done = s_q.done;
  assign pm_nack = s_q.nack;
  assign pm_rdata = s_q.rdata;
  assign req_tgl = s_q.req_tgl;
  assign req_cmd = s_q.cmd;
  assign req_write = s_q.wr;
  assign req_wdata = s_q.wdata;
endmodule

// ### rtl/rorc_core.sv
// Reference trim and margin-high offset registers with reference builder
`timescale 1ns/1ps
// Function
// - The signed trim offset is added to the reference while regulating.
// - Store-all copies the trim offset to nonvolatile storage, restore reloads it.
// - A loop follower ignores every write to either offset register.
// - A loop follower NACKs any access, flags invalid command and alerts.
// - Both offsets use the fixed linear format with exponent minus nine.
// - Reference is setpoint times scale plus trim plus selected margins.
// - Trim is a sign-extended 16-bit word, zero by default.
// - Trim accepts codes from minus 64 to plus 63.
// - Out-of-range offset writes saturate toward the requested direction.
// - Out-of-range writes alert and set the summary and invalid-data bits.
// - The combined reference is bounded by the max and min limits.
// - The reference ramps at the rate of the converter state.
// - Margin-high is a non-negative shift applied only when selected.
// - Margin-high accepts 0 to 31; upper bits read as zero.
// - Margin-high restores to 9 or 15 by the option bit, never stored.
// - The margin-low term lies in minus 64 to minus 1 and applies when selected.
module rorc_core (
  input wire logic mclk,
  input wire logic rst,
  input wire logic lclk,
  input wire logic pm_valid,
  input wire logic pm_write,
  input wire logic [7:0] pm_cmd,
  input wire logic [15:0] pm_wdata,
  output logic pm_busy,
  output logic pm_done,
  output logic pm_nack,
  output logic [15:0] pm_rdata,
  input wire logic loop_follower,
  input wire logic margin_high_restore_select,
  input wire logic store_all,
  input wire logic restore_all,
  input wire logic clear_faults,
  input wire rorc_pkg::rorc_conv_e conv_state,
  input wire logic [7:0] operation,
  input wire logic [15:0] vout_command,
  input wire logic [7:0] vout_scale_loop,
  input wire logic [15:0] vout_max,
  input wire logic [15:0] vout_min,
  input wire logic [15:0] margin_low_offset,
  input wire logic [15:0] ton_rise_step,
  input wire logic [15:0] transition_step,
  input wire logic [15:0] toff_fall_step,
  output logic [15:0] error_amp_reference,
  output logic status_cml,
  output logic cml_invalid_data,
  output logic invalid_command_fault,
  output logic smbalert_n
);
  import rorc_pkg::*;

  typedef struct packed {
    rorc_phase_e phase;
    logic [1:0] init_cnt;
    logic fol_s1;
    logic fol_s2;
    logic sel_s1;
    logic sel_s2;
    logic req_s1;
    logic req_s2;
    logic req_seen;
    logic ack_tgl;
    logic nack;
    logic [15:0] rdata;
    logic [TRIM_W_C-1:0] trim;
    logic [TRIM_W_C-1:0] nvm_trim;
    logic [MH_W_C-1:0] mh;
    logic cml;
    logic inv_data;
    logic icf;
    logic alert_n;
    logic [15:0] target;
    logic [15:0] ref_code;
  } rorc_core_s;

  rorc_core_s s_q;
  rorc_core_s s_d;

  logic req_tgl;
  logic [7:0] req_cmd;
  logic req_write;
  logic [15:0] req_wdata;
  logic req_go;

  function automatic logic is_offset_cmd(input logic [7:0] c);
    is_offset_cmd = (c == CMD_TRIM_C) || (c == CMD_MARGIN_HIGH_C);
  endfunction

  function automatic logic trim_oor(input logic [15:0] w);
    trim_oor = ($signed(w) > TRIM_MAX_C) || ($signed(w) < TRIM_MIN_C);
  endfunction

  function automatic logic mh_oor(input logic [15:0] w);
    mh_oor = ($signed(w) > MH_MAX_C) || ($signed(w) < MH_MIN_C);
  endfunction

  function automatic logic [15:0] trim_word(input logic [TRIM_W_C-1:0] t);
    trim_word = {{(16-TRIM_W_C){t[TRIM_W_C-1]}}, t};
  endfunction

  function automatic logic [MH_W_C-1:0] mh_restore(input logic sel);
    mh_restore = sel ? MH_RESTORE1_C[MH_W_C-1:0] : MH_RESTORE0_C[MH_W_C-1:0];
  endfunction

  rorc_link_port u_link (
    .lclk(lclk),
    .rst(rst),
    .pm_valid(pm_valid),
    .pm_write(pm_write),
    .pm_cmd(pm_cmd),
    .pm_wdata(pm_wdata),
    .pm_busy(pm_busy),
    .pm_done(pm_done),
    .pm_nack(pm_nack),
    .pm_rdata(pm_rdata),
    .req_tgl(req_tgl),
    .req_cmd(req_cmd),
    .req_write(req_write),
    .req_wdata(req_wdata),
    .ack_tgl(s_q.ack_tgl),
    .ack_nack(s_q.nack),
    .ack_rdata(s_q.rdata)
  );

  assign req_go = (s_q.phase == PH_READY) && (s_q.req_s2 != s_q.req_seen);

  always_comb begin
    logic [23:0] prod;
    logic signed [19:0] sum;
    logic signed [15:0] ml;
    logic [15:0] step;
    logic signed [16:0] diff;
    logic set_cml;
    logic set_icf;
    prod = 24'(vout_command) * 24'(vout_scale_loop);
    sum = '0;
    ml = '0;
    step = '0;
    diff = '0;
    set_cml = 1'b0;
    set_icf = 1'b0;
    s_d = s_q;
    s_d.fol_s1 = loop_follower;
    s_d.fol_s2 = s_q.fol_s1;
    s_d.sel_s1 = margin_high_restore_select;
    s_d.sel_s2 = s_q.sel_s1;
    s_d.req_s1 = req_tgl;
    s_d.req_s2 = s_q.req_s1;

    case (s_q.phase)
      PH_INIT: begin
        // Wait for the strap synchronisers, then load offsets
        if (s_q.init_cnt == INIT_CYC_C) begin
          s_d.trim = s_q.nvm_trim;
          s_d.mh = mh_restore(s_q.sel_s2);
          s_d.phase = PH_READY;
        end else begin
          s_d.init_cnt = s_q.init_cnt + 2'h1;
        end
      end
      PH_READY: begin
        if (store_all) begin
          s_d.nvm_trim = s_q.trim;
        end
        if (restore_all) begin
          s_d.trim = s_q.nvm_trim;
          s_d.mh = mh_restore(s_q.sel_s2);
        end
      end
      default: begin
        s_d.phase = PH_INIT;
      end
    endcase

    if (req_go) begin
      s_d.req_seen = s_q.req_s2;
      s_d.ack_tgl = ~s_q.ack_tgl;
      s_d.nack = 1'b0;
      s_d.rdata = '0;
      if (s_q.fol_s2 || !is_offset_cmd(req_cmd)) begin
        // Follower or unknown code: no read, no write, fault and alert
        s_d.nack = 1'b1;
        set_icf = 1'b1;
      end else if (!req_write) begin
        if (req_cmd == CMD_TRIM_C) begin
          s_d.rdata = trim_word(s_q.trim);
        end else begin
          s_d.rdata = {{(16-MH_W_C){1'b0}}, s_q.mh};
        end
      end else if (req_cmd == CMD_TRIM_C) begin
        // Exponent fixed at VOUT_EXP_C: code is taken as is
        if ($signed(req_wdata) > TRIM_MAX_C) begin
          s_d.trim = TRIM_MAX_C[TRIM_W_C-1:0];
        end else if ($signed(req_wdata) < TRIM_MIN_C) begin
          s_d.trim = TRIM_MIN_C[TRIM_W_C-1:0];
        end else begin
          s_d.trim = req_wdata[TRIM_W_C-1:0];
        end
        set_cml = trim_oor(req_wdata);
      end else begin
        if ($signed(req_wdata) > MH_MAX_C) begin
          s_d.mh = MH_MAX_C[MH_W_C-1:0];
        end else if ($signed(req_wdata) < MH_MIN_C) begin
          s_d.mh = MH_MIN_C[MH_W_C-1:0];
        end else begin
          s_d.mh = req_wdata[MH_W_C-1:0];
        end
        set_cml = mh_oor(req_wdata);
      end
    end

    // Flags: a new event wins over a clear in the same cycle
    if (clear_faults) begin
      s_d.cml = 1'b0;
      s_d.inv_data = 1'b0;
      s_d.icf = 1'b0;
      s_d.alert_n = 1'b1;
    end
    if (set_cml) begin
      s_d.cml = 1'b1;
      s_d.inv_data = 1'b1;
      s_d.alert_n = 1'b0;
    end
    if (set_icf) begin
      s_d.cml = 1'b1;
      s_d.icf = 1'b1;
      s_d.alert_n = 1'b0;
    end

    // Margin-low term kept within its range
    if ($signed(margin_low_offset) > ML_MAX_C) begin
      ml = ML_MAX_C;
    end else if ($signed(margin_low_offset) < ML_MIN_C) begin
      ml = ML_MIN_C;
    end else begin
      ml = $signed(margin_low_offset);
    end

    sum = $signed({3'h0, prod[23:SCALE_SHIFT_C]});
    sum = sum + 20'(signed'(trim_word(s_q.trim)));
    if (operation[OP_MARGIN_HIGH_BIT_C]) begin
      sum = sum + $signed({15'h0, s_q.mh});
    end
    if (operation[OP_MARGIN_LOW_BIT_C]) begin
      sum = sum + 20'(ml);
    end

    if ((conv_state == CONV_OFF) || (conv_state == CONV_SOFT_STOP)) begin
      s_d.target = '0;
    end else if (sum > $signed({4'h0, vout_max})) begin
      s_d.target = vout_max;
    end else if (sum < $signed({4'h0, vout_min})) begin
      s_d.target = vout_min;
    end else begin
      s_d.target = sum[15:0];
    end

    case (conv_state)
      CONV_SOFT_START: step = ton_rise_step;
      CONV_SOFT_STOP: step = toff_fall_step;
      default: step = transition_step;
    endcase
    diff = $signed({1'b0, s_q.target}) - $signed({1'b0, s_q.ref_code});
    if (diff > $signed({1'b0, step})) begin
      s_d.ref_code = s_q.ref_code + step;
    end else if (diff < -$signed({1'b0, step})) begin
      s_d.ref_code = s_q.ref_code - step;
    end else begin
      s_d.ref_code = s_q.target;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
      s_q.phase <= PH_INIT;
      s_q.trim <= TRIM_RST_C[TRIM_W_C-1:0];
      s_q.nvm_trim <= TRIM_RST_C[TRIM_W_C-1:0];
      s_q.mh <= MH_RESTORE0_C[MH_W_C-1:0];
      s_q.alert_n <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign error_amp_reference = s_q.ref_code;
  assign status_cml = s_q.cml;
  assign cml_invalid_data = s_q.inv_data;
  assign invalid_command_fault = s_q.icf;
  assign smbalert_n = s_q.alert_n;

  AST_FOLLOWER_KEEPS: assert property (
    @(posedge mclk) disable iff (rst)
    req_go && s_q.fol_s2 && !restore_all |=>
      $stable(s_q.trim) && $stable(s_q.mh)
  ) else $error("follower write changed an offset");

  AST_FOLLOWER_NACK: assert property (
    @(posedge mclk) disable iff (rst)
    req_go && s_q.fol_s2 |=>
      s_q.nack && s_q.icf && !s_q.alert_n && $changed(s_q.ack_tgl)
  ) else $error("follower access not refused");

  AST_TRIM_HIGH_SAT: assert property (
    @(posedge mclk) disable iff (rst)
    req_go && !s_q.fol_s2 && req_write && (req_cmd == CMD_TRIM_C)
      && ($signed(req_wdata) > 16'sh003F) && !restore_all
      |=> (trim_word(s_q.trim) == 16'h003F)
  ) else $error("trim did not saturate high");

  AST_TRIM_LOW_SAT: assert property (
    @(posedge mclk) disable iff (rst)
    req_go && !s_q.fol_s2 && req_write && (req_cmd == CMD_TRIM_C)
      && ($signed(req_wdata) < 16'shFFC0) && !restore_all
      |=> (trim_word(s_q.trim) == 16'hFFC0)
  ) else $error("trim did not saturate low");

  AST_OOR_FLAGS: assert property (
    @(posedge mclk) disable iff (rst)
    req_go && !s_q.fol_s2 && req_write && (req_cmd == CMD_MARGIN_HIGH_C)
      && ($signed(req_wdata) > 16'sh001F)
      |=> s_q.cml && s_q.inv_data && !s_q.alert_n && (s_q.mh == 5'h1F)
  ) else $error("out of range margin write not flagged");

  AST_TRIM_READ: assert property (
    @(posedge mclk) disable iff (rst)
    req_go && !s_q.fol_s2 && !req_write && (req_cmd == CMD_TRIM_C)
      |=> (s_q.rdata == trim_word($past(s_q.trim))) && !s_q.nack
  ) else $error("trim read value wrong");

  AST_STORE: assert property (
    @(posedge mclk) disable iff (rst)
    (s_q.phase == PH_READY) && store_all |=> s_q.nvm_trim == $past(s_q.trim)
  ) else $error("store did not copy trim");

  AST_RESTORE_MH: assert property (
    @(posedge mclk) disable iff (rst)
    (s_q.phase == PH_READY) && restore_all && !req_go |=>
      s_q.mh == ($past(s_q.sel_s2) ? 5'h0F : 5'h09)
  ) else $error("margin high restore value wrong");

  AST_TARGET_BOUND: assert property (
    @(posedge mclk) disable iff (rst)
    (conv_state == CONV_STEADY) && (vout_min <= vout_max) |=>
      (s_q.target <= $past(vout_max)) && (s_q.target >= $past(vout_min))
  ) else $error("reference target outside limits");

  AST_INIT_HOLDS: assert property (
    @(posedge mclk) disable iff (rst)
    (s_q.phase == PH_INIT) |=> $stable(s_q.ack_tgl)
  ) else $error("host answered before offsets loaded");
endmodule

// ### testbench/rorc_host.sv
// Host model issuing single-word command transfers on the link clock
`timescale 1ns/1ps
module rorc_host (
  input wire logic lclk,
  input wire logic pm_done,
  input wire logic pm_nack,
  input wire logic [15:0] pm_rdata,
  output logic pm_valid,
  output logic pm_write,
  output logic [7:0] pm_cmd,
  output logic [15:0] pm_wdata
);
  initial begin
    pm_valid = 1'b0;
    pm_write = 1'b0;
    pm_cmd = 8'h00;
    pm_wdata = 16'h0000;
  end
  // One word per request; qualifiers hold until the answer edge
  task automatic xfer(input logic wr, input logic [7:0] cmd,
      input logic [15:0] wd, output logic [15:0] rd, output logic nk,
      output logic late);
    int n;
    late = 1'b1;
    n = 0;
    @(posedge lclk);
    #1;
    pm_valid = 1'b1;
    pm_write = wr;
    pm_cmd = cmd;
    pm_wdata = wd;
    @(posedge lclk);
    #1;
    pm_valid = 1'b0;
    while (late && n < 400) begin
      @(posedge lclk);
      #1;
      if (pm_done === 1'b1) begin
        rd = pm_rdata;
        nk = pm_nack;
        late = 1'b0;
      end
      n++;
    end
    #1;
    // Released lines must not keep showing the last word
    pm_wdata = ~pm_wdata;
    pm_cmd = ~pm_cmd;
  endtask
endmodule

// ### testbench/testbench.sv
// Self-checking bench for the reference offset command registers
`timescale 1ns/1ps
module testbench;
  import rorc_pkg::*;
  typedef struct packed {
    logic [7:0] cmd;
    logic [15:0] wd;
    logic [15:0] rb;
    logic bad;
  } rorc_row_s;
  logic mclk, lclk, rst, pm_valid, pm_write, pm_busy, pm_done, pm_nack;
  logic [7:0] pm_cmd, operation, vout_scale_loop;
  logic [15:0] pm_wdata, pm_rdata, vout_command, vout_max, vout_min;
  logic [15:0] margin_low_offset, ton_rise_step, transition_step;
  logic [15:0] toff_fall_step, error_amp_reference, rd;
  logic loop_follower, margin_high_restore_select, store_all, restore_all;
  logic clear_faults, status_cml, cml_invalid_data, invalid_command_fault;
  logic smbalert_n, nk, late;
  rorc_conv_e conv_state;
  int miscompares, checks;
  rorc_row_s rows [9] = '{
    '{CMD_TRIM_C, 16'h0005, 16'h0005, 1'b0},
    '{CMD_TRIM_C, 16'hFFC0, 16'hFFC0, 1'b0},
    '{CMD_TRIM_C, 16'h003F, 16'h003F, 1'b0},
    '{CMD_TRIM_C, 16'h0040, 16'h003F, 1'b1},
    '{CMD_TRIM_C, 16'hFF00, 16'hFFC0, 1'b1},
    '{CMD_MARGIN_HIGH_C, 16'h001F, 16'h001F, 1'b0},
    '{CMD_MARGIN_HIGH_C, 16'h0020, 16'h001F, 1'b1},
    '{CMD_MARGIN_HIGH_C, 16'h8000, 16'h0000, 1'b1},
    '{CMD_MARGIN_HIGH_C, 16'h0000, 16'h0000, 1'b0}};

  rorc_core rorc_core_i (.mclk(mclk), .rst(rst), .lclk(lclk),
    .pm_valid(pm_valid), .pm_write(pm_write), .pm_cmd(pm_cmd),
    .pm_wdata(pm_wdata), .pm_busy(pm_busy), .pm_done(pm_done),
    .pm_nack(pm_nack), .pm_rdata(pm_rdata), .loop_follower(loop_follower),
    .margin_high_restore_select(margin_high_restore_select),
    .store_all(store_all), .restore_all(restore_all),
    .clear_faults(clear_faults), .conv_state(conv_state),
    .operation(operation), .vout_command(vout_command),
    .vout_scale_loop(vout_scale_loop), .vout_max(vout_max),
    .vout_min(vout_min), .margin_low_offset(margin_low_offset),
    .ton_rise_step(ton_rise_step), .transition_step(transition_step),
    .toff_fall_step(toff_fall_step),
    .error_amp_reference(error_amp_reference), .status_cml(status_cml),
    .cml_invalid_data(cml_invalid_data),
    .invalid_command_fault(invalid_command_fault), .smbalert_n(smbalert_n));

  rorc_host rorc_host_i (.lclk(lclk), .pm_done(pm_done), .pm_nack(pm_nack),
    .pm_rdata(pm_rdata), .pm_valid(pm_valid), .pm_write(pm_write),
    .pm_cmd(pm_cmd), .pm_wdata(pm_wdata));

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  initial begin
    lclk = 1'b0;
    #3.7;
    forever #6 lclk = ~lclk;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic check16(input string nm, input logic [15:0] e,
      input logic [15:0] g);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic check1(input string nm, input logic e, input logic g);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic summarize();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic acc(input logic wr, input logic [7:0] c,
      input logic [15:0] wd);
    rorc_host_i.xfer(wr, c, wd, rd, nk, late);
    check1("transfer answered", 1'b0, late);
    if (late) begin
      summarize();
    end
    tick(1);
  endtask
  task automatic pulse_clear();
    clear_faults = 1'b1;
    tick(1);
    clear_faults = 1'b0;
    tick(1);
  endtask
  // Follows the ramp; each move stays within the step of the state
  task automatic wait_ref(input logic [15:0] e, input int step,
      input int lim);
    int n;
    int prev;
    int d;
    n = 0;
    prev = int'(error_amp_reference);
    while (error_amp_reference !== e && n < lim) begin
      tick(1);
      d = int'(error_amp_reference) - prev;
      prev = int'(error_amp_reference);
      check1("ramp move within step", 1'b1, d <= step && d >= -step);
      n++;
    end
    check16("reference", e, error_amp_reference);
    if (n >= lim) begin
      summarize();
    end
  endtask

  initial begin
    miscompares = 0;
    checks = 0;
    rst = 1'b1;
    loop_follower = 1'b0;
    margin_high_restore_select = 1'b0;
    store_all = 1'b0;
    restore_all = 1'b0;
    clear_faults = 1'b0;
    conv_state = CONV_OFF;
    operation = 8'h00;
    vout_command = 16'h0200;
    vout_scale_loop = 8'h40;
    vout_max = 16'hFFFF;
    vout_min = 16'h0000;
    margin_low_offset = 16'hFFF6;
    ton_rise_step = 16'h0002;
    transition_step = 16'h0004;
    toff_fall_step = 16'h0008;
    tick(2);
    rst = 1'b0;
    check1("alert idle", 1'b1, smbalert_n);
    check16("reference at reset", 16'h0000, error_amp_reference);
    acc(1'b0, CMD_TRIM_C, 16'h0000);
    check16("trim reset", TRIM_RST_C, rd);
    acc(1'b0, CMD_MARGIN_HIGH_C, 16'h0000);
    check16("margin high reset", MH_RESTORE0_C, rd);
    foreach (rows[i]) begin
      pulse_clear();
      acc(1'b1, rows[i].cmd, rows[i].wd);
      check1("write nack", 1'b0, nk);
      acc(1'b0, rows[i].cmd, 16'h0000);
      check16("readback", rows[i].rb, rd);
      check1("invalid data", rows[i].bad, cml_invalid_data);
      check1("summary cml", rows[i].bad, status_cml);
      check1("alert", ~rows[i].bad, smbalert_n);
    end
    acc(1'b1, CMD_TRIM_C, 16'h0005);
    acc(1'b1, CMD_MARGIN_HIGH_C, 16'h001F);
    conv_state = CONV_SOFT_START;
    wait_ref(16'd261, 2, 135);
    conv_state = CONV_STEADY;
    operation = 8'h20;
    wait_ref(16'd292, 4, 12);
    conv_state = CONV_TOFF_DELAY;
    operation = 8'h30;
    wait_ref(16'd282, 4, 7);
    margin_low_offset = 16'hFF00;
    operation = 8'h10;
    wait_ref(16'd197, 4, 26);
    conv_state = CONV_STEADY;
    operation = 8'h20;
    vout_max = 16'h010E;
    wait_ref(16'd270, 4, 23);
    vout_max = 16'hFFFF;
    vout_min = 16'h012C;
    wait_ref(16'd300, 4, 12);
    conv_state = CONV_SOFT_STOP;
    wait_ref(16'd0, 8, 42);
    store_all = 1'b1;
    tick(1);
    store_all = 1'b0;
    acc(1'b1, CMD_TRIM_C, 16'h0011);
    margin_high_restore_select = 1'b1;
    tick(3);
    restore_all = 1'b1;
    tick(1);
    restore_all = 1'b0;
    acc(1'b0, CMD_TRIM_C, 16'h0000);
    check16("trim restored", 16'h0005, rd);
    acc(1'b0, CMD_MARGIN_HIGH_C, 16'h0000);
    check16("margin high restored", MH_RESTORE1_C, rd);
    pulse_clear();
    check1("fault cleared", 1'b0, invalid_command_fault);
    loop_follower = 1'b1;
    tick(3);
    acc(1'b1, CMD_TRIM_C, 16'h0022);
    check1("follower write nack", 1'b1, nk);
    check1("follower fault", 1'b1, invalid_command_fault);
    check1("follower alert", 1'b0, smbalert_n);
    acc(1'b0, CMD_MARGIN_HIGH_C, 16'h0000);
    check1("follower read nack", 1'b1, nk);
    loop_follower = 1'b0;
    tick(3);
    acc(1'b0, CMD_TRIM_C, 16'h0000);
    check1("leader read nack", 1'b0, nk);
    check16("trim kept", 16'h0005, rd);
    pulse_clear();
    acc(1'b0, 8'hD6, 16'h0000);
    check1("unknown code nack", 1'b1, nk);
    check1("unknown code fault", 1'b1, invalid_command_fault);
    // Reset in mid-run: offsets reload, host waits through start-up
    rst = 1'b1;
    tick(2);
    check1("busy in reset", 1'b0, pm_busy);
    check1("fault in reset", 1'b0, invalid_command_fault);
    check1("alert in reset", 1'b1, smbalert_n);
    rst = 1'b0;
    fork
      acc(1'b0, CMD_TRIM_C, 16'h0000);
      begin
        tick(3);
        check1("busy while pending", 1'b1, pm_busy);
      end
    join
    check1("busy after answer", 1'b0, pm_busy);
    check16("trim after reset", TRIM_RST_C, rd);
    acc(1'b0, CMD_MARGIN_HIGH_C, 16'h0000);
    check16("margin high after reset", MH_RESTORE1_C, rd);
    summarize();
  end
endmodule
